// [design/tcs_pkg.sv]
// types for the temperature conversion sequencer
// assumes nothing beyond the constants header
package tcs_pkg;
  typedef enum logic [3:0] {
    TCS_IDLE = 4'b0001,
    TCS_CONV = 4'b0010,
    TCS_WAIT = 4'b0100,
    TCS_STOP = 4'b1000
  } tcs_state_type;
endpackage

// [design/tcs_regs.svh]
// constants for the temperature conversion sequencer
// assumes a 125 MHz sys_clk; included by the sequencer and tick modules, not by the package
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
`define TCS_ADDR_CFG 4'h0
`define TCS_ADDR_THIGH 4'h1
`define TCS_ADDR_TLOW 4'h2
`define TCS_ADDR_TEMP 4'h3
`define TCS_ADDR_STAT 4'h4
`define TCS_ADDR_MASK 4'h5
`define TCS_ADDR_CMD 4'h6
`define TCS_CFG_RST 8'h02
`define TCS_THIGH_RST 8'h3c
`define TCS_TLOW_RST 8'hf6
`define TCS_GC_RESET 8'h06
`define TCS_CLK_KHZ 125000
`define TCS_CONV_MS 26
`define TCS_TICK_DIV 125000
`define TCS_PER_RATE0 13'd4000
`define TCS_PER_RATE1 13'd1000
`define TCS_PER_RATE2 13'd250
`define TCS_PER_RATE3 13'd125
`define TCS_MODE_SHUT 2'h0
`define TCS_MODE_ONE 2'h1
`define TCS_CFG_LC 2
`define TCS_CFG_FL 3
`define TCS_CFG_FH 4
`define TCS_CFG_CR 6
`define TCS_CFG_M 0
`endif

// [design/tcs_seq.sv]
// conversion sequencer, limit watchdog and register file
// assumes a register master on the plain port and a sampled converter result
`timescale 1ns/1ns
`include "tcs_regs.svh"
// What this block does
// [RULE_01] a finished result above the upper limit sets the over-limit flag.
// [RULE_02] a finished result below the lower limit sets the under-limit flag.
// [RULE_03] with flag hold set, flags stay asserted until the configuration is read.
// [RULE_04] a configuration read clears both flags, as does an in-window result without hold.
// [RULE_05] reset clears both flags and the hold bit.
// [RULE_06] rate select 00/01/10/11 gives a 4000/1000/250/125 ms rate delay after each 26 ms conversion.
// [RULE_07] a conversion lasts 26 ms, then the converter idles out the rate delay.
// [RULE_08] after reset a conversion starts at once.
// [RULE_09] mode 00 enters shutdown only after the running conversion ends.
// [RULE_10] in shutdown only the register port stays alive.
// [RULE_11] writing mode 01 in shutdown performs exactly one conversion.
// [RULE_12] mode reads 01 during a single shot and 00 after it.
// [RULE_13] with the upper mode bit set, conversions repeat at the selected rate.
// [RULE_14] results carry one degree per step.
// [RULE_15] a general-call reset command restores all registers to power-up values.
// [RULE_16] flags are set only at the end of a conversion, from its result.
module tcs_seq
  import tcs_pkg::*;
#(
  parameter int TICK_DIV = `TCS_TICK_DIV,
  parameter int CONV_MS = `TCS_CONV_MS
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] temp_in,
  output logic conv_active,
  output logic conv_done,
  output logic irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  tcs_state_type state;
  logic [7:0] cfg;
  logic [7:0] thigh;
  logic [7:0] tlow;
  logic [7:0] temp;
  logic [1:0] stat;
  logic [1:0] mask;
  logic [12:0] ms_cnt;
  logic tick;
  logic soft_rst;
  logic rd_cfg;
  logic done;

  function automatic logic [12:0] period_ms(input logic [1:0] sel);
    case (sel) // [RULE_06]
      2'h0: period_ms = `TCS_PER_RATE0;
      2'h1: period_ms = `TCS_PER_RATE1;
      2'h2: period_ms = `TCS_PER_RATE2;
      default: period_ms = `TCS_PER_RATE3;
    endcase
  endfunction

  // general call command write restores power-up values
  assign soft_rst = wr && addr == `TCS_ADDR_CMD && wdata == `TCS_GC_RESET; // [RULE_15]
  assign rd_cfg = rd && addr == `TCS_ADDR_CFG;
  assign done = state == TCS_CONV && tick && ms_cnt == 13'(CONV_MS - 1);
  assign conv_active = state == TCS_CONV;
  assign irq = |(stat & mask);

  // clock only runs outside shutdown
  tcs_tick #(.DIV(TICK_DIV)) u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(state != TCS_STOP), // [RULE_10]
    .tick(tick)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst || soft_rst) begin
      state <= TCS_CONV; // [RULE_08]
      ms_cnt <= 13'h0;
    end else begin
      case (state)
        TCS_CONV: begin
          if (tick) begin
            ms_cnt <= ms_cnt + 13'h1;
          end
          if (done) begin // [RULE_07]
            // wait counts from zero, the full rate delay follows the conversion
            ms_cnt <= 13'h0;
            if (cfg[`TCS_CFG_M+1]) begin
              state <= TCS_WAIT; // [RULE_13]
            end else begin
              state <= TCS_STOP; // [RULE_09]
            end
          end
        end
        TCS_WAIT: begin
          if (!cfg[`TCS_CFG_M+1]) begin
            state <= TCS_STOP;
            ms_cnt <= 13'h0;
          end else if (tick) begin
            if (ms_cnt + 13'h1 >= period_ms(cfg[`TCS_CFG_CR+:2])) begin // [RULE_07]
              state <= TCS_CONV;
              ms_cnt <= 13'h0;
            end else begin
              ms_cnt <= ms_cnt + 13'h1;
            end
          end
        end
        TCS_STOP: begin
          ms_cnt <= 13'h0;
          // single shot or continuous request wakes the converter
          if (wr && addr == `TCS_ADDR_CFG && wdata[`TCS_CFG_M+:2] != `TCS_MODE_SHUT) begin
            state <= TCS_CONV; // [RULE_11]
          end
        end
        default: begin
          state <= TCS_CONV;
          ms_cnt <= 13'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst || soft_rst) begin
      conv_done <= 1'b0;
      temp <= 8'h0;
    end else begin
      conv_done <= done;
      if (done) begin
        temp <= temp_in; // [RULE_14]
      end
    end
  end

  // ----------------------------------------
  // configuration and limit flags
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst || soft_rst) begin
      cfg <= `TCS_CFG_RST; // [RULE_05]
      thigh <= `TCS_THIGH_RST;
      tlow <= `TCS_TLOW_RST;
    end else begin
      if (wr && addr == `TCS_ADDR_CFG) begin
        // flags are read-only; mode bits writeable
        cfg[`TCS_CFG_M+:2] <= wdata[`TCS_CFG_M+:2];
        cfg[`TCS_CFG_LC] <= wdata[`TCS_CFG_LC];
        cfg[`TCS_CFG_CR+:2] <= wdata[`TCS_CFG_CR+:2];
      end else if (done && cfg[`TCS_CFG_M+:2] == `TCS_MODE_ONE) begin
        cfg[`TCS_CFG_M+:2] <= `TCS_MODE_SHUT; // [RULE_12]
      end
      if (wr && addr == `TCS_ADDR_THIGH) begin
        thigh <= wdata;
      end
      if (wr && addr == `TCS_ADDR_TLOW) begin
        tlow <= wdata;
      end
      if (done) begin // [RULE_16]
        if ($signed(temp_in) > $signed(thigh)) begin
          cfg[`TCS_CFG_FH] <= 1'b1; // [RULE_01]
        end else if (!cfg[`TCS_CFG_LC] && $signed(temp_in) >= $signed(tlow)) begin
          cfg[`TCS_CFG_FH] <= 1'b0; // [RULE_04]
        end
        if ($signed(temp_in) < $signed(tlow)) begin
          cfg[`TCS_CFG_FL] <= 1'b1; // [RULE_02]
        end else if (!cfg[`TCS_CFG_LC] && $signed(temp_in) <= $signed(thigh)) begin
          cfg[`TCS_CFG_FL] <= 1'b0; // [RULE_04]
        end
      end else if (rd_cfg) begin
        cfg[`TCS_CFG_FH] <= 1'b0; // [RULE_03]
        cfg[`TCS_CFG_FL] <= 1'b0; // [RULE_04]
      end
    end
  end

  // ----------------------------------------
  // interrupt status, set wins over clear
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst || soft_rst) begin
      stat <= 2'h0;
      mask <= 2'h0;
    end else begin
      if (wr && addr == `TCS_ADDR_MASK) begin
        mask <= wdata[1:0];
      end
      stat <= (stat & ~((wr && addr == `TCS_ADDR_STAT) ? wdata[1:0] : 2'h0))
        | {done && ($signed(temp_in) > $signed(thigh) || $signed(temp_in) < $signed(tlow)),
           done};
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata <= 8'h0;
    end else if (rd) begin
      case (addr)
        `TCS_ADDR_CFG: rdata <= cfg;
        `TCS_ADDR_THIGH: rdata <= thigh;
        `TCS_ADDR_TLOW: rdata <= tlow;
        `TCS_ADDR_TEMP: rdata <= temp;
        `TCS_ADDR_STAT: rdata <= {6'h0, stat};
        `TCS_ADDR_MASK: rdata <= {6'h0, mask};
        default: rdata <= 8'h0;
      endcase
    end else begin
      rdata <= 8'h0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_OVER: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_01]
    done && !soft_rst && $signed(temp_in) > $signed(thigh) |=> cfg[`TCS_CFG_FH])
    else $error("over flag not set");
  AST_UNDER: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_02]
    done && !soft_rst && $signed(temp_in) < $signed(tlow) |=> cfg[`TCS_CFG_FL])
    else $error("under flag not set");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_03]
    cfg[`TCS_CFG_LC] && cfg[`TCS_CFG_FH] && !rd_cfg && !soft_rst |=> cfg[`TCS_CFG_FH])
    else $error("held flag dropped");
  AST_RDCLR: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_04]
    rd_cfg && !done |=> !cfg[`TCS_CFG_FH] && !cfg[`TCS_CFG_FL])
    else $error("read did not clear flags");
  AST_RESET: assert property (@(posedge sys_clk) // [RULE_05]
    !nrst |=> cfg[`TCS_CFG_FH+:1] == 1'b0 && !cfg[`TCS_CFG_FL] && !cfg[`TCS_CFG_LC])
    else $error("reset values wrong");
  AST_START: assert property (@(posedge sys_clk) // [RULE_08]
    !nrst |=> state == TCS_CONV)
    else $error("no conversion after reset");
  AST_SHUT: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_09]
    state == TCS_CONV && !done && !soft_rst |=> state == TCS_CONV)
    else $error("conversion cut short");
  AST_ONESHOT: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_12]
    done && !wr && !soft_rst && cfg[`TCS_CFG_M+:2] == `TCS_MODE_ONE
    |=> cfg[`TCS_CFG_M+:2] == `TCS_MODE_SHUT && state == TCS_STOP)
    else $error("single shot did not end");
  AST_CONT: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_13]
    done && !soft_rst && cfg[`TCS_CFG_M+1] |=> state == TCS_WAIT)
    else $error("continuous mode stopped");
  AST_SLEEP: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_10]
    state == TCS_STOP |-> !tick)
    else $error("timebase runs in shutdown");
  AST_STAY: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_10]
    state == TCS_STOP && !(wr && addr == `TCS_ADDR_CFG) && !soft_rst
    |=> state == TCS_STOP)
    else $error("shutdown left without request");
  AST_RDTEMP: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_10]
    rd && addr == `TCS_ADDR_TEMP && !soft_rst |=> rdata == $past(temp))
    else $error("result read wrong");
  // limit flags: window clear without hold, untouched between conversions
  AST_INWIN: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_04]
    done && !soft_rst && !cfg[`TCS_CFG_LC]
    && $signed(temp_in) <= $signed(thigh) && $signed(temp_in) >= $signed(tlow)
    |=> !cfg[`TCS_CFG_FH] && !cfg[`TCS_CFG_FL])
    else $error("in-window flags not cleared");
  AST_LATCH: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_16]
    !done && !rd_cfg && !soft_rst
    |=> $stable(cfg[`TCS_CFG_FH]) && $stable(cfg[`TCS_CFG_FL]))
    else $error("flags moved between conversions");
  AST_TEMP: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_14]
    done && !soft_rst |=> temp == $past(temp_in))
    else $error("result not captured");
  AST_DONE: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_07]
    done && !soft_rst |=> conv_done && stat[0])
    else $error("conversion end not flagged");
  // a stale count here would shorten every rate delay by the conversion time
  AST_WAITIN: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_07]
    done && !soft_rst && cfg[`TCS_CFG_M+1] |=> ms_cnt == 13'h0)
    else $error("wait count not restarted");
  AST_WAITEND: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_06]
    state == TCS_WAIT && cfg[`TCS_CFG_M+1] && tick && !soft_rst
    && ms_cnt + 13'h1 >= period_ms(cfg[`TCS_CFG_CR+:2])
    |=> state == TCS_CONV && ms_cnt == 13'h0)
    else $error("rate delay not ended");
  AST_WAKE: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_11]
    state == TCS_STOP && wr && addr == `TCS_ADDR_CFG
    && wdata[`TCS_CFG_M+:2] == `TCS_MODE_ONE
    |=> state == TCS_CONV && ms_cnt == 13'h0)
    else $error("single shot not started");
  AST_ONEREAD: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_12]
    state == TCS_CONV && !done && !wr && !soft_rst
    && cfg[`TCS_CFG_M+:2] == `TCS_MODE_ONE
    |=> cfg[`TCS_CFG_M+:2] == `TCS_MODE_ONE)
    else $error("single shot mode lost early");
  // command reset must reach every register, not only the sequencer
  AST_GCRST: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_15]
    soft_rst |=> state == TCS_CONV && cfg == `TCS_CFG_RST && thigh == `TCS_THIGH_RST
    && tlow == `TCS_TLOW_RST && stat == 2'h0 && mask == 2'h0)
    else $error("command reset incomplete");
endmodule

// [design/tcs_tick.sv]
// millisecond tick divider for the sequencer
// assumes one free running sys_clk
`timescale 1ns/1ns
`include "tcs_regs.svh"
module tcs_tick #(
  parameter int DIV = `TCS_TICK_DIV
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  output logic tick
);
  logic [31:0] cnt;
  logic tick_q;
  // gated so a tick queued as run drops never leaks into shutdown
  assign tick = tick_q && run;
  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) begin
      cnt <= 32'h0;
      tick_q <= 1'b0;
    end else if (cnt == 32'(DIV - 1)) begin
      cnt <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      cnt <= cnt + 32'h1;
      tick_q <= 1'b0;
    end
  end
endmodule

// [testbench/tb_temp_conversion_sequencer.sv]
// self-checking bench for the conversion sequencer
// assumes a shortened ms tick and a behavioural sensor model
`timescale 1ns/1ns
module tb_temp_conversion_sequencer;
  logic sys_clk, nrst, wr, rd, conv_active, conv_done, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, temp_in, tgt, d;
  logic [7:0] tv [6];
  int n_mismatch, checked, n;
  localparam int TD = 4;
  localparam int CM = 26;
  int pms [4] = '{4000, 1000, 250, 125};
  tcs_seq #(.TICK_DIV(TD), .CONV_MS(CM)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .temp_in(temp_in),
    .conv_active(conv_active), .conv_done(conv_done), .irq(irq));
  tcs_sensor_model u_sensor (.sys_clk(sys_clk), .conv_active(conv_active),
    .target(tgt), .temp_out(temp_in));
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // cycle counts allow a few cycles of pipeline slack
  task automatic near(input string nm, input int e, input int g);
    checked++;
    if (g < e - 8 || g > e + 8) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge sys_clk);
    wr <= 0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1;
    @(posedge sys_clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task automatic wait_done(output int c);
    for (c = 1; c < 20000; c++) begin
      @(posedge sys_clk);
      #1;
      if (conv_done === 1'b1) return;
    end
    n_mismatch++;
    $display("[FAIL] conv_done expected 1 seen 0");
    complete_run();
  endtask
  task automatic one_shot(input logic [7:0] c, input logic [7:0] t);
    tgt <= t;
    wr_reg(4'h0, c | 8'h01);
  endtask
  task automatic idle_chk();
    n = 0;
    repeat (300) begin
      @(posedge sys_clk);
      #1 n += int'(conv_active);
    end
    chk("idle", 8'h00, 8'(n));
  endtask
  function automatic logic [7:0] exp_cfg(input logic [7:0] c, input logic [7:0] t);
    return {c[7:6], 1'b0, $signed(t) > 8'sh3c, $signed(t) < 8'shf6, c[2], 2'b00};
  endfunction
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    nrst = 0; wr = 0; rd = 0; addr = 0; wdata = 0; tgt = 8'h14;
    n_mismatch = 0; checked = 0;
    void'($urandom(32'hc3f3b24b));
    repeat (10) @(posedge sys_clk);
    nrst <= 1;
    #1 chk("busy", 8'h01, {7'h0, conv_active});
    rd_reg(4'h0, d); chk("cfg", 8'h02, d);
    wait_done(n); near("first", CM * TD - 3, n);
    $display("test reset done");
    tv = '{8'h3c, 8'h3d, 8'hf6, 8'hf5, 8'($urandom), 8'($urandom)};
    wr_reg(4'h0, 8'h00);
    foreach (tv[i]) begin
      one_shot(8'h00, tv[i]);
      rd_reg(4'h0, d); chk("mode", 8'h01, {6'h0, d[1:0]});
      wait_done(n);
      rd_reg(4'h0, d); chk("flags", exp_cfg(8'h00, tv[i]), d);
    end
    rd_reg(4'h0, d); chk("cleared", 8'h00, d);
    idle_chk();
    rd_reg(4'h3, d); chk("temp", tv[5], d);
    $display("test single shot done");
    one_shot(8'h04, 8'h70); wait_done(n);
    one_shot(8'h04, 8'h14); wait_done(n);
    rd_reg(4'h0, d); chk("held", 8'h14, d);
    one_shot(8'h00, 8'h70); wait_done(n);
    one_shot(8'h00, 8'h14); wait_done(n);
    rd_reg(4'h0, d); chk("window", 8'h00, d);
    wr_reg(4'h0, 8'h18);
    rd_reg(4'h0, d); chk("ro", 8'h00, d);
    rd_reg(4'hf, d); chk("unmapped", 8'h00, d);
    $display("test flags done");
    wr_reg(4'h4, 8'hff); wr_reg(4'h5, 8'h01);
    chk("irq", 8'h00, {7'h0, irq});
    one_shot(8'h00, 8'h14); wait_done(n);
    @(posedge sys_clk); #1 chk("irq", 8'h01, {7'h0, irq});
    wr_reg(4'h4, 8'h01); chk("irq", 8'h00, {7'h0, irq});
    $display("test irq done");
    for (int r = 3; r >= 0; r--) begin
      wr_reg(4'h0, {2'(r), 6'h02});
      wait_done(n); wait_done(n);
      near("period", (pms[r] + CM) * TD, n);
    end
    $display("test rates done");
    wr_reg(4'h6, 8'h06);
    chk("gc busy", 8'h01, {7'h0, conv_active});
    rd_reg(4'h0, d); chk("gc cfg", 8'h02, d);
    wr_reg(4'h0, 8'h00);
    chk("finish", 8'h01, {7'h0, conv_active});
    wait_done(n);
    idle_chk();
    rd_reg(4'h3, d); chk("temp", tgt, d);
    $display("test shutdown done");
    complete_run();
  end
endmodule

// [testbench/tcs_sensor_model.sv]
// sensor front end model feeding the sequencer's result input
// assumes the bench sets the temperature to present
`timescale 1ns/1ns
module tcs_sensor_model (
  input wire logic sys_clk,
  input wire logic conv_active,
  input wire logic [7:0] target,
  output logic [7:0] temp_out
);
  // result only valid while converting; noise otherwise, so a late sample shows
  always_ff @(posedge sys_clk) begin
    temp_out <= conv_active ? target : ~temp_out;
  end
endmodule
